// file: rtl/option_byte_config_decoder.sv
// Option byte store, decoder and Avalon-MM programming access.
//
// Notes on behaviour
// - Option byte 0 bit 7 set makes halt entry with the watchdog active generate a reset.
// - Option byte 0 bit 6 clear gives an always-on hardware watchdog, set gives a software-enabled one.
// - Option byte 0 bit 5 clear selects the PLL clock, set selects the oscillator clock.
// - Option byte 0 bits 4:3 enable both detectors (00), low-voltage only (01), none (10), 11 undefined.
// - Option byte 0 bit 2 selects a 4096 (clear) or 256 (set) cycle reset and halt-exit delay.
// - With the PLL clock selected the delay is forced to 4096 cycles.
// - Option byte 0 bit 1 clear enables the input halving divider, set bypasses it.
// - Option byte 0 bit 0 clear protects user flash from reads and writes in test and programming modes.
// - Erasing option bytes while protected first erases all user memory.
// - Option byte 1 bits 7:5 select package 32/44/56/64 pin, or 80 pin for any 1xx code.
// - Option byte 1 bits 1:0 give motor outputs under reset hi-Z, low, high, hi-Z.
// - Erased option bytes read all ones so every option defaults to one.
// - Option bytes are reachable only while programming mode is active.
//
// Our own choices: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module option_byte_config_decoder
    import opt_cfg_pkg::*;
#(
    parameter int LONG_CYCLES  = RST_CYC_LONG,
    parameter int SHORT_CYCLES = RST_CYC_SHORT
) (
    input  wire logic        i_sys_clk,
    input  wire logic        i_rst,
    input  wire logic [3:0]  i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [31:0] i_avs_writedata,
    input  wire logic [3:0]  i_avs_byteenable,
    output logic [31:0]      o_avs_readdata,
    output logic             o_avs_waitrequest,
    input  wire logic        i_test_mode,
    input  wire logic        i_halt_entry,
    input  wire logic        i_halt_exit,
    output logic             o_halt_reset_when_watchdog,
    output logic             o_watchdog_hw_always_on,
    output logic             o_clock_source_select,
    output logic             o_low_voltage_detector,
    output logic             o_aux_voltage_detector,
    output logic             o_reset_cycle_long,
    output logic             o_input_halving_divider,
    output logic             o_readout_protect,
    output logic [2:0]       o_package_select,
    output logic [4:0]       o_package_onehot,
    output logic             o_motor_out,
    output logic             o_motor_oe,
    output logic             o_user_erase,
    output logic             o_user_access_block,
    output logic             o_reset_phase
);
    // Non-volatile content survives i_rst; it starts out erased
    logic [7:0]  nv0_q = OPT_ERASED;
    logic [7:0]  nv1_q = OPT_ERASED;
    logic [7:0]  opt0_q, opt1_q;
    logic        prog_q;
    logic        erase_req_q;
    logic        ack_q;
    logic [31:0] rdata_q;
    logic        er_done;
    logic        er_busy;
    logic        dly_busy;

    // Avalon slave: one wait state, answer on the second edge of the request
    wire req      = i_avs_read | i_avs_write;
    wire hit_opt0 = (i_avs_address == ADDR_OPT0);
    wire hit_opt1 = (i_avs_address == ADDR_OPT1);
    wire hit_ctrl = (i_avs_address == ADDR_CTRL);
    wire hit_stat = (i_avs_address == ADDR_STATUS);
    wire take     = req & ack_q;
    wire wr_take  = take & i_avs_write & i_avs_byteenable[0];
    wire nv_open  = prog_q & ~er_busy;
    wire wr_opt0  = wr_take & hit_opt0 & nv_open;
    wire wr_opt1  = wr_take & hit_opt1 & nv_open;
    wire wr_ctrl  = wr_take & hit_ctrl;
    wire erase_go = wr_ctrl & i_avs_writedata[CTRL_ERASE_BIT] & prog_q & ~er_busy;

    wire [31:0] rd_mux =
        (hit_opt0 & prog_q) ? {24'h000000, nv0_q} :
        (hit_opt1 & prog_q) ? {24'h000000, nv1_q} :
        hit_ctrl            ? {30'h00000000, erase_req_q, prog_q} :
        hit_stat            ? {28'h0000000, dly_busy, o_readout_protect, er_busy, prog_q} :
                              32'h00000000;

    assign o_avs_waitrequest = req & ~ack_q;
    assign o_avs_readdata    = rdata_q;

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            ack_q   <= 1'b0;
            rdata_q <= 32'h00000000;
        end else begin
            ack_q   <= req & ~ack_q;
            if (req & ~ack_q & i_avs_read)
                rdata_q <= rd_mux;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            prog_q      <= 1'b0;
            erase_req_q <= 1'b0;
        end else begin
            if (wr_ctrl)
                prog_q <= i_avs_writedata[CTRL_PROG_BIT];
            if (erase_go)
                erase_req_q <= 1'b1;
            else if (er_done)
                erase_req_q <= 1'b0;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (er_done) begin
            nv0_q <= OPT_ERASED;
            nv1_q <= OPT_ERASED;
        end else begin
            if (wr_opt0)
                nv0_q <= i_avs_writedata[7:0];
            if (wr_opt1)
                nv1_q <= i_avs_writedata[7:0];
        end
    end

    erase_sequencer u_erase (
        .i_sys_clk    (i_sys_clk),
        .i_rst        (i_rst),
        .i_req        (erase_go),
        .i_protected  (~opt0_q[PROTECT_BIT]),
        .o_user_erase (o_user_erase),
        .o_done       (er_done)
    );
    assign er_busy = erase_req_q;

    // Options are sampled while reset is held and frozen afterwards
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            opt0_q <= nv0_q;
            opt1_q <= nv1_q;
        end
    end

    wire [1:0] vd_code  = opt0_q[VD_HI_BIT:VD_LO_BIT];
    wire [1:0] mot_code = opt1_q[MOTOR_HI_BIT:MOTOR_LO_BIT];
    wire       pll_sel  = ~opt0_q[CLK_SRC_BIT];
    wire       long_dly = ~opt0_q[RST_CYC_BIT] | pll_sel;

    assign o_halt_reset_when_watchdog = opt0_q[HALT_RST_BIT];
    assign o_watchdog_hw_always_on    = ~opt0_q[WDG_TYPE_BIT];
    assign o_clock_source_select      = opt0_q[CLK_SRC_BIT];
    // Code 11 is undefined; it is treated as both off, the safe reading
    assign o_low_voltage_detector     = (vd_code == VD_BOTH_ON) | (vd_code == VD_LOW_ONLY);
    assign o_aux_voltage_detector     = (vd_code == VD_BOTH_ON);
    assign o_reset_cycle_long         = long_dly;
    assign o_input_halving_divider    = ~opt0_q[HALVE_BIT];
    assign o_readout_protect          = ~opt0_q[PROTECT_BIT];
    assign o_user_access_block        = o_readout_protect & (i_test_mode | prog_q);
    assign o_package_select           = opt1_q[PKG_HI_BIT:PKG_LO_BIT];
    assign o_package_onehot           = opt1_q[PKG_HI_BIT] ? 5'h10 :
                                        (5'h01 << opt1_q[PKG_HI_BIT-1:PKG_LO_BIT]);
    wire   mot_drive                  = (mot_code == MOTOR_LOW) | (mot_code == MOTOR_HIGH);
    assign o_motor_oe                 = (i_rst | o_reset_phase) & mot_drive;
    assign o_motor_out                = (mot_code == MOTOR_HIGH);

    // Reset itself loads the delay; only halt exit has to restart it
    wire dly_start = i_halt_exit;
    reset_delay_counter #(
        .LONG_CYCLES  (LONG_CYCLES),
        .SHORT_CYCLES (SHORT_CYCLES)
    ) u_delay (
        .i_sys_clk (i_sys_clk),
        .i_rst     (i_rst),
        .i_start   (dly_start),
        .i_long    (long_dly),
        .o_busy    (dly_busy)
    );
    assign o_reset_phase = dly_busy;

    // Checks
    ack_one_wait_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        $rose(req) |-> o_avs_waitrequest ##1 !o_avs_waitrequest)
        else $error("waitrequest did not drop after one cycle");
    prog_gate_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (!prog_q && !er_done) |=> $stable(nv0_q) && $stable(nv1_q))
        else $error("option byte changed outside programming");
    hold_opts_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        ##1 $stable(opt0_q) && $stable(opt1_q))
        else $error("latched options changed during operation");
    pll_forces_long_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        pll_sel |-> o_reset_cycle_long)
        else $error("PLL selected without long delay");
    wipe_before_clear_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (erase_go && o_readout_protect) |=> o_user_erase[*8])
        else $error("user memory not wiped before option erase");
    erased_after_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        er_done |=> nv0_q == OPT_ERASED && nv1_q == OPT_ERASED)
        else $error("options not all ones after erase");
    short_delay_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (i_halt_exit && !long_dly) |=> dly_busy [*8] ##[1:250] !dly_busy)
        else $error("short delay length wrong");
    aux_needs_low_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        o_aux_voltage_detector |-> o_low_voltage_detector)
        else $error("aux detector on without low-voltage detector");
    pkg80_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        o_package_select[2] |-> o_package_onehot == 5'h10)
        else $error("80 pin package not selected");
    motor_hiz_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (mot_code == MOTOR_HIZ_A || mot_code == MOTOR_HIZ_B) |-> !o_motor_oe)
        else $error("motor output driven in hi-Z code");
    protect_block_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (o_readout_protect && i_test_mode) |-> o_user_access_block)
        else $error("protected flash left open in test mode");

    write_cov_c: cover property (@(posedge i_sys_clk) disable iff (i_rst) wr_opt0);
    erase_cov_c: cover property (@(posedge i_sys_clk) disable iff (i_rst) erase_go && o_readout_protect);
    halt_cov_c:  cover property (@(posedge i_sys_clk) disable iff (i_rst) i_halt_exit ##1 dly_busy);
endmodule // option_byte_config_decoder

// file: rtl/opt_cfg_pkg.sv
// Package: option byte layout, reset values, register map and timing counts.
package opt_cfg_pkg;
    localparam logic [7:0] OPT_ERASED          = 8'hFF;
    localparam int         HALT_RST_BIT        = 7;
    localparam int         WDG_TYPE_BIT        = 6;
    localparam int         CLK_SRC_BIT         = 5;
    localparam int         VD_HI_BIT           = 4;
    localparam int         VD_LO_BIT           = 3;
    localparam int         RST_CYC_BIT         = 2;
    localparam int         HALVE_BIT           = 1;
    localparam int         PROTECT_BIT         = 0;
    localparam int         PKG_HI_BIT          = 7;
    localparam int         PKG_LO_BIT          = 5;
    localparam int         MOTOR_HI_BIT        = 1;
    localparam int         MOTOR_LO_BIT        = 0;
    localparam logic [1:0] VD_BOTH_ON          = 2'h0;
    localparam logic [1:0] VD_LOW_ONLY         = 2'h1;
    localparam logic [1:0] VD_BOTH_OFF         = 2'h2;
    localparam logic [1:0] MOTOR_HIZ_A         = 2'h0;
    localparam logic [1:0] MOTOR_LOW           = 2'h1;
    localparam logic [1:0] MOTOR_HIGH          = 2'h2;
    localparam logic [1:0] MOTOR_HIZ_B         = 2'h3;
    localparam int         RST_CYC_LONG        = 4096;
    localparam int         RST_CYC_SHORT       = 256;
    localparam logic [3:0] ADDR_OPT0           = 4'h0;
    localparam logic [3:0] ADDR_OPT1           = 4'h4;
    localparam logic [3:0] ADDR_CTRL           = 4'h8;
    localparam logic [3:0] ADDR_STATUS         = 4'hC;
    localparam int         CTRL_PROG_BIT       = 0;
    localparam int         CTRL_ERASE_BIT      = 1;
    localparam int         ERASE_CYCLES        = 16;
    typedef enum logic [1:0] {PKG32, PKG44, PKG56, PKG64_80} unused_t;
endpackage

// file: rtl/reset_delay_counter.sv
// Reset phase and halt exit delay counter.
`timescale 1ns/1ps
module reset_delay_counter
    import opt_cfg_pkg::*;
#(
    parameter int LONG_CYCLES  = RST_CYC_LONG,
    parameter int SHORT_CYCLES = RST_CYC_SHORT
) (
    input  wire logic i_sys_clk,
    input  wire logic i_rst,
    input  wire logic i_start,
    input  wire logic i_long,
    output logic      o_busy
);
    initial begin
        if (SHORT_CYCLES < 1 || LONG_CYCLES < SHORT_CYCLES || LONG_CYCLES > 65535)
            $error("reset_delay_counter: bad cycle counts");
    end
    logic [15:0] cnt_q;
    wire  [15:0] load_val = i_long ? 16'(LONG_CYCLES) : 16'(SHORT_CYCLES);
    always_ff @(posedge i_sys_clk) begin
        // Held reset keeps the selected length loaded, so the phase counts from the release edge
        if (i_rst)
            cnt_q <= load_val;
        else if (i_start)
            cnt_q <= load_val;
        else if (cnt_q != 16'h0000)
            cnt_q <= cnt_q - 16'h0001;
    end
    assign o_busy = (cnt_q != 16'h0000);
endmodule // reset_delay_counter

// file: rtl/erase_sequencer.sv
// Sequencer that wipes user memory, when protected, before option bytes may be erased.
`timescale 1ns/1ps
module erase_sequencer
    import opt_cfg_pkg::*;
#(
    parameter int CYCLES = ERASE_CYCLES
) (
    input  wire logic i_sys_clk,
    input  wire logic i_rst,
    input  wire logic i_req,
    input  wire logic i_protected,
    output logic      o_user_erase,
    output logic      o_done
);
    typedef enum {IDLE, WIPE, FINISH} er_state_t;
    er_state_t   st_q;
    logic [7:0]  cnt_q;
    initial begin
        if (CYCLES < 1 || CYCLES > 255)
            $error("erase_sequencer: bad cycle count");
    end
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            st_q  <= IDLE;
            cnt_q <= 8'h00;
        end else begin
            case (st_q)
                IDLE: if (i_req) begin
                    st_q  <= i_protected ? WIPE : FINISH;
                    cnt_q <= 8'(CYCLES);
                end
                WIPE: begin
                    cnt_q <= cnt_q - 8'h01;
                    if (cnt_q == 8'h01)
                        st_q <= FINISH;
                end
                FINISH: st_q <= IDLE;
                default: st_q <= IDLE;
            endcase
        end
    end
    assign o_user_erase = (st_q == WIPE);
    assign o_done       = (st_q == FINISH);
endmodule // erase_sequencer

// file: tb/prog_tool.sv
// Programming tool model: Avalon-MM master that loads the option bytes.
`timescale 1ns/1ps
module prog_tool (
    input  wire logic        i_sys_clk,
    input  wire logic [31:0] i_readdata,
    input  wire logic        i_waitrequest,
    output logic [3:0]       o_address,
    output logic             o_read,
    output logic             o_write,
    output logic [31:0]      o_writedata,
    output logic [3:0]       o_byteenable
);
    initial begin
        o_address    = 4'h0;
        o_read       = 1'b0;
        o_write      = 1'b0;
        o_writedata  = 32'h0;
        o_byteenable = 4'hF;
    end

    // Any address is driven; the bench also touches the option bytes before CTRL enters programming mode
    task automatic xfer(input logic we, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge i_sys_clk);
        o_address   <= a;
        o_writedata <= d;
        o_write     <= we;
        o_read      <= !we;
        do @(posedge i_sys_clk); while (i_waitrequest !== 1'b0);
        q = i_readdata;
        o_read      <= 1'b0;
        o_write     <= 1'b0;
        // Released lines show garbage so a stale value is never trusted
        o_address   <= ~a;
        o_writedata <= ~d;
    endtask
endmodule // prog_tool

// file: tb/tb_option_byte_config_decoder.sv
// Self-checking bench for the option byte decoder.
`timescale 1ns/1ps
module tb_option_byte_config_decoder;
    import opt_cfg_pkg::*;
    localparam int LONG_N  = 64;
    localparam int SHORT_N = 16;
    logic        i_sys_clk = 1'b0;
    logic        i_rst = 1'b1;
    logic        i_test_mode = 1'b0;
    logic        i_halt_exit = 1'b0;
    wire  [3:0]  addr;
    wire         rd;
    wire         wr;
    wire  [31:0] wdata;
    wire  [3:0]  be;
    wire  [31:0] rdq;
    wire         wait_req;
    wire  [15:0] cfg;
    wire         mot_out;
    wire         mot_oe;
    wire         erase;
    wire         block;
    wire         phase;
    int          err_total = 0;
    int          checked = 0;
    int          seed = 88;
    int          n;
    logic [31:0] rdata;
    logic [7:0]  o0;
    logic [7:0]  o1;
    logic [7:0]  p0 = 8'hFF;
    logic [7:0]  p1 = 8'hFF;

    always #5 i_sys_clk = ~i_sys_clk;

    prog_tool u_tool (.i_sys_clk(i_sys_clk), .i_readdata(rdq), .i_waitrequest(wait_req), .o_address(addr),
        .o_read(rd), .o_write(wr), .o_writedata(wdata), .o_byteenable(be));

    option_byte_config_decoder #(.LONG_CYCLES(LONG_N), .SHORT_CYCLES(SHORT_N)) dut (
        .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr),
        .i_avs_writedata(wdata), .i_avs_byteenable(be), .o_avs_readdata(rdq), .o_avs_waitrequest(wait_req),
        .i_test_mode(i_test_mode), .i_halt_entry(1'b0), .i_halt_exit(i_halt_exit),
        .o_halt_reset_when_watchdog(cfg[15]), .o_watchdog_hw_always_on(cfg[14]), .o_clock_source_select(cfg[13]),
        .o_low_voltage_detector(cfg[12]), .o_aux_voltage_detector(cfg[11]), .o_reset_cycle_long(cfg[10]),
        .o_input_halving_divider(cfg[9]), .o_readout_protect(cfg[8]), .o_package_select(cfg[7:5]),
        .o_package_onehot(cfg[4:0]), .o_motor_out(mot_out), .o_motor_oe(mot_oe), .o_user_erase(erase),
        .o_user_access_block(block), .o_reset_phase(phase));

    function automatic logic [15:0] exp_cfg(input logic [7:0] a, input logic [7:0] b);
        logic [1:0] vd;
        vd = a[VD_HI_BIT:VD_LO_BIT];
        return {a[7], !a[6], a[5], vd == VD_BOTH_ON || vd == VD_LOW_ONLY, vd == VD_BOTH_ON,
                !a[2] || !a[5], !a[1], !a[0], b[7:5], b[7] ? 5'h10 : 5'h01 << b[6:5]};
    endfunction

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_cfg(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: config %h expected %h", $time, got, exp);
        end
    endtask

    task automatic test_done();
        $display("Comparisons %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic bus_rd(input logic [3:0] a, input logic [31:0] exp);
        u_tool.xfer(1'b0, a, 32'h0, rdata);
        chk_word(rdata, exp);
    endtask

    task automatic count_high(input logic sel, input int exp);
        // Sampling starts in the current cycle so the first busy cycle is not lost
        n = 0;
        for (int k = 0; k < 5000; k++) begin
            #1;
            if ((sel ? erase : phase) === 1'b1)
                n++;
            else if (n > 0)
                break;
            @(posedge i_sys_clk);
            i_halt_exit <= 1'b0;
        end
        @(posedge i_sys_clk);
        chk_word(n, exp);
    endtask

    task automatic do_reset(input logic [7:0] a, input logic [7:0] b);
        i_rst <= 1'b1;
        repeat (4) @(posedge i_sys_clk);
        #1;
        chk_word({mot_oe, mot_out & mot_oe}, b[1:0] == MOTOR_LOW ? 2'h2 : b[1:0] == MOTOR_HIGH ? 2'h3 : 2'h0);
        @(posedge i_sys_clk);
        i_rst <= 1'b0;
        count_high(1'b0, (!a[2] || !a[5]) ? LONG_N : SHORT_N);
        chk_cfg(cfg, exp_cfg(a, b));
        chk_word({mot_oe, 1'b0}, 2'h0);
        p0 = a;
        p1 = b;
        $display("Reset done with options %h %h", a, b);
    endtask

    initial begin
        repeat (5) @(posedge i_sys_clk);
        do_reset(OPT_ERASED, OPT_ERASED);
        bus_rd(ADDR_OPT0, 32'h0);
        u_tool.xfer(1'b1, ADDR_OPT0, 32'h0, rdata);
        u_tool.xfer(1'b1, ADDR_CTRL, 32'h1, rdata);
        bus_rd(ADDR_OPT0, 32'hFF);
        bus_rd(4'h2, 32'h0);
        // Every detector, package and motor code is forced at least twice across the loop
        for (int i = 0; i < 16; i++) begin
            o0 = 8'($random(seed));
            o1 = 8'($random(seed));
            o0[VD_HI_BIT:VD_LO_BIT] = 2'(i);
            o1[PKG_HI_BIT:PKG_LO_BIT] = 3'(i);
            o1[MOTOR_HI_BIT:MOTOR_LO_BIT] = 2'(i >> 2);
            o0[PROTECT_BIT] = (i % 3 == 0) ? 1'b0 : 1'b1;
            // Last pass keeps the short delay so the halt exit check reaches it
            if (i == 15) o0 = o0 | 8'h24;
            i_test_mode <= (i % 2 == 1);
            @(posedge i_sys_clk);
            chk_word(block, 32'(!p0[0] && i_test_mode));
            u_tool.xfer(1'b1, ADDR_CTRL, 32'h1, rdata);
            u_tool.xfer(1'b1, ADDR_OPT0, {24'h0, o0}, rdata);
            u_tool.xfer(1'b1, ADDR_OPT1, {24'h0, o1}, rdata);
            bus_rd(ADDR_OPT1, {24'h0, o1});
            chk_cfg(cfg, exp_cfg(p0, p1));
            do_reset(o0, o1);
        end
        @(posedge i_sys_clk);
        i_halt_exit <= 1'b1;
        count_high(1'b0, (!p0[2] || !p0[5]) ? LONG_N : SHORT_N);
        $display("Halt exit delay checked");
        // PLL-clocked boards keep the long delay while protection is on
        u_tool.xfer(1'b1, ADDR_CTRL, 32'h1, rdata);
        u_tool.xfer(1'b1, ADDR_OPT0, 32'hDA, rdata);
        do_reset(8'hDA, p1);
        i_test_mode <= 1'b0;
        u_tool.xfer(1'b1, ADDR_CTRL, 32'h1, rdata);
        #1;
        chk_word(block, 32'h1);
        u_tool.xfer(1'b1, ADDR_CTRL, 32'h3, rdata);
        count_high(1'b1, ERASE_CYCLES);
        repeat (3) @(posedge i_sys_clk);
        bus_rd(ADDR_OPT0, 32'hFF);
        bus_rd(ADDR_OPT1, 32'hFF);
        bus_rd(ADDR_STATUS, 32'h5);
        $display("Protected erase checked");
        test_done();
    end

    initial begin
        repeat (20000) @(posedge i_sys_clk);
        err_total++;
        test_done();
    end
endmodule // tb_option_byte_config_decoder
